// ==== dsp_mode_and_volume_ramp_ctrl.v ====
// Control bank for processing mode, forced high-Z and master volume ramping.
// Assumes a decoded host register port and sample ticks on the CLK domain;
// mute, emergency and bridged-mode inputs come from logic on the same clock.
`timescale 1ns/1ps
`include "dsp_vol_consts.vh"

// Behaviour
// - Left force bit set holds the left channel in high-Z over its normal state.
// - Right force bit set holds the right channel in high-Z over its normal state.
// - A forced channel leaves high-Z when its bit is written to zero or while the bridged mono output is selected.
// - Forced high-Z on both channels does nothing while the bridged mono output is selected.
// - The program field selects RAM for 00 and ROM programs 1 to 3 for 01 to 11, reset 01.
// - Coefficient source one selects built-in ROM coefficients, zero the host-loaded ones.
// - Volume code steps 0.5 dB per code from +24 dB at zero, with 0 dB at 0x30 as reset.
// - Volume code 0xFE is the -103 dB floor and 0xFF is full mute.
// - One volume setting drives both channels together.
// - Ramp-down updates come every 1, 2 or 4 samples; code 11 jumps to the target at once.
// - Each ramp-down update lowers gain by 4, 2, 1 or 0.5 dB, resetting to 0.5 dB.
// - Ramp-up updates come every 1, 2 or 4 samples; code 11 restores the target at once.
// - Each ramp-up update raises gain by 4, 2, 1 or 0.5 dB, resetting to 0.5 dB.
// - A clock error or power loss ramps down with the separate emergency rate and step.
module dsp_mode_and_volume_ramp_ctrl #(
  parameter PACE_W = 2
) (
  input  wire       CLK,
  input  wire       RESET,
  input  wire       REG_WE,
  input  wire       REG_RE,
  input  wire [7:0] REG_ADDR,
  input  wire [7:0] REG_WDATA,
  output reg  [7:0] REG_RDATA,
  output reg        REG_RVALID,
  input  wire       FS_TICK,
  input  wire       SOFT_MUTE,
  input  wire       EMERGENCY,
  input  wire       PARALLEL_BRIDGED_OUTPUT,
  output reg        FORCE_LEFT_HIGHZ,
  output reg        FORCE_RIGHT_HIGHZ,
  output reg  [1:0] PROGRAM_SEL,
  output reg        BUILTIN_COEFF_SEL,
  output reg  [7:0] VOLUME_LEVEL,
  output reg        VOLUME_MUTED,
  output wire       RAMP_ACTIVE
);

  // Reset words kept sized so the applied fields can be sliced out of them
  localparam [7:0] PROG_RST_WORD = `RST_PROGRAM_AND_HIGHZ;
  localparam [7:0] CTRL_RST_WORD = `RST_PROCESSING_CONTROL;

  // Software-visible registers
  reg  [7:0] prog_q;
  reg  [7:0] ctrl_q;
  reg  [7:0] vol_q;
  reg  [7:0] ramp_q;
  reg  [7:0] emerg_q;

  // Ramp state
  reg  [7:0] cur_q;
  reg  [7:0] cur_d;
  reg        dir_down_q;
  reg  [7:0] target;
  reg        going_down;
  reg        going_up;
  reg  [1:0] rate_sel;
  reg  [1:0] step_sel;
  reg  [8:0] step_codes;
  reg  [8:0] cur_wide;
  reg  [8:0] tgt_wide;
  wire       update;
  wire       restart;
  reg  [7:0] rdata_d;

  // Per-channel high-Z requests and flops, index 1 left and 0 right
  wire [1:0] hiz_req;
  wire [1:0] hiz_out;

  wire hit_prog  = (REG_ADDR == `OFS_PROGRAM_AND_HIGHZ);
  wire hit_ctrl  = (REG_ADDR == `OFS_PROCESSING_CONTROL);
  wire hit_vol   = (REG_ADDR == `OFS_MASTER_VOLUME);
  wire hit_ramp  = (REG_ADDR == `OFS_VOLUME_RAMP_SETUP);
  wire hit_emerg = (REG_ADDR == `OFS_EMERGENCY_RAMP);

  // Register writes; reserved bits store as read/write, status bits stay zero
  always @(posedge CLK) begin
    if (RESET) begin
      prog_q  <= `RST_PROGRAM_AND_HIGHZ;
      ctrl_q  <= `RST_PROCESSING_CONTROL;
      vol_q   <= `RST_MASTER_VOLUME;
      ramp_q  <= `RST_VOLUME_RAMP_SETUP;
      emerg_q <= `RST_EMERGENCY_RAMP;
    end else if (REG_WE) begin
      if (hit_prog) begin
        prog_q <= REG_WDATA;
      end
      if (hit_ctrl) begin
        ctrl_q <= REG_WDATA & ~`CTRL_RO_MASK;
      end
      if (hit_vol) begin
        vol_q <= REG_WDATA;
      end
      if (hit_ramp) begin
        ramp_q <= REG_WDATA;
      end
      if (hit_emerg) begin
        emerg_q <= REG_WDATA;
      end
    end
  end

  // Read data registered, valid one cycle after the strobe; unmapped reads zero
  always @* begin
    rdata_d = 8'h00;
    if (hit_prog) begin
      rdata_d = prog_q;
    end else if (hit_ctrl) begin
      rdata_d = ctrl_q;
    end else if (hit_vol) begin
      rdata_d = vol_q;
    end else if (hit_ramp) begin
      rdata_d = ramp_q;
    end else if (hit_emerg) begin
      rdata_d = emerg_q;
    end
  end

  always @(posedge CLK) begin
    if (RESET) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RE;
      if (REG_RE) begin
        REG_RDATA <= rdata_d;
      end
    end
  end

  assign hiz_req = {prog_q[`BIT_FORCE_LEFT], prog_q[`BIT_FORCE_RIGHT]};

  // High-Z overrides; bridged mono output masks both, no latching beyond the bits
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_hiz
      reg held_q;
      always @(posedge CLK) begin
        if (RESET) begin
          held_q <= 1'b0;
        end else begin
          held_q <= hiz_req[ch] && !PARALLEL_BRIDGED_OUTPUT;
        end
      end
      assign hiz_out[ch] = held_q;
    end
  endgenerate

  // Outputs come straight from the per-channel flops
  always @* begin
    FORCE_LEFT_HIGHZ  = hiz_out[1];
    FORCE_RIGHT_HIGHZ = hiz_out[0];
  end

  // Program and coefficient source applied only on the sample tick
  always @(posedge CLK) begin
    if (RESET) begin
      PROGRAM_SEL       <= PROG_RST_WORD[`PROG_HI:`PROG_LO];
      BUILTIN_COEFF_SEL <= CTRL_RST_WORD[`BIT_BUILTIN_COEFF];
    end else if (FS_TICK) begin
      PROGRAM_SEL       <= prog_q[`PROG_HI:`PROG_LO];
      BUILTIN_COEFF_SEL <= ctrl_q[`BIT_BUILTIN_COEFF];
    end
  end

  // Ramp target; emergency and soft mute both aim at full mute
  always @* begin
    if (EMERGENCY || SOFT_MUTE) begin
      target = `VOL_MUTE_CODE;
    end else begin
      target = vol_q;
    end
  end

  // Direction; a larger code means more attenuation
  always @* begin
    going_down = (cur_q < target);
    going_up   = (cur_q > target);
  end

  // Rate and step; emergency wins over the normal fall setting
  always @* begin
    if (EMERGENCY) begin
      rate_sel = emerg_q[`FALL_RATE_HI:`FALL_RATE_LO];
      step_sel = emerg_q[`FALL_STEP_HI:`FALL_STEP_LO];
    end else if (going_down) begin
      rate_sel = ramp_q[`FALL_RATE_HI:`FALL_RATE_LO];
      step_sel = ramp_q[`FALL_STEP_HI:`FALL_STEP_LO];
    end else begin
      rate_sel = ramp_q[`RISE_RATE_HI:`RISE_RATE_LO];
      step_sel = ramp_q[`RISE_STEP_HI:`RISE_STEP_LO];
    end
  end

  // Step size in half-dB codes
  always @* begin
    case (step_sel)
      `STEP_4DB:     step_codes = `VOL_CODES_4DB;
      `STEP_2DB:     step_codes = `VOL_CODES_2DB;
      `STEP_1DB:     step_codes = `VOL_CODES_1DB;
      `STEP_HALF_DB: step_codes = `VOL_CODES_HALF_DB;
      default:       step_codes = `VOL_CODES_HALF_DB;
    endcase
  end

  // A direction reversal restarts pacing so the new ramp gets a full period
  assign restart     = (going_down && !dir_down_q) || (going_up && dir_down_q);
  assign RAMP_ACTIVE = going_down || going_up;

  fs_update_pacer #(
    .CNT_W (PACE_W)
  ) u_pacer (
    .CLK     (CLK),
    .RESET   (RESET),
    .FS_TICK (FS_TICK),
    .RESTART (restart),
    .RATE    (rate_sel),
    .UPDATE  (update)
  );

  // Next applied code; 9-bit sums so the clamp never wraps
  always @* begin
    cur_wide = {1'b0, cur_q};
    tgt_wide = {1'b0, target};
    cur_d    = cur_q;
    if (going_down) begin
      if (rate_sel == `RATE_INSTANT) begin
        cur_d = target;
      end else if (update) begin
        if (cur_wide + step_codes >= tgt_wide) begin
          cur_d = target;
        end else begin
          cur_d = cur_q + step_codes[7:0];
        end
      end
    end else if (going_up) begin
      if (rate_sel == `RATE_INSTANT) begin
        cur_d = target;
      end else if (update) begin
        if (cur_wide <= tgt_wide + step_codes) begin
          cur_d = target;
        end else begin
          cur_d = cur_q - step_codes[7:0];
        end
      end
    end
  end

  // Applied volume is one code shared by both channels
  always @(posedge CLK) begin
    if (RESET) begin
      cur_q        <= `RST_MASTER_VOLUME;
      dir_down_q   <= 1'b0;
      VOLUME_LEVEL <= `RST_MASTER_VOLUME;
      VOLUME_MUTED <= 1'b0;
    end else begin
      cur_q        <= cur_d;
      VOLUME_LEVEL <= cur_d;
      VOLUME_MUTED <= (cur_d == `VOL_MUTE_CODE);
      if (going_down) begin
        dir_down_q <= 1'b1;
      end else if (going_up) begin
        dir_down_q <= 1'b0;
      end
    end
  end

endmodule

// ==== dsp_vol_consts.vh ====
// Constants for the processing-mode and digital volume control bank.
// Assumes inclusion by bare name from the design files of this block.
`ifndef DSP_VOL_CONSTS_VH
`define DSP_VOL_CONSTS_VH

// Register offsets on the host control port
`define OFS_PROGRAM_AND_HIGHZ   8'h40
`define OFS_PROCESSING_CONTROL  8'h46
`define OFS_MASTER_VOLUME       8'h4C
`define OFS_VOLUME_RAMP_SETUP   8'h4E
`define OFS_EMERGENCY_RAMP      8'h4F

// Reset values
`define RST_PROGRAM_AND_HIGHZ   8'h01
`define RST_PROCESSING_CONTROL  8'h01
`define RST_MASTER_VOLUME       8'h30
`define RST_VOLUME_RAMP_SETUP   8'h33
`define RST_EMERGENCY_RAMP      8'h30

// Field positions
`define BIT_FORCE_LEFT          3
`define BIT_FORCE_RIGHT         2
`define PROG_HI                 1
`define PROG_LO                 0
`define BIT_BUILTIN_COEFF       0
`define CTRL_RO_MASK            8'h06
`define FALL_RATE_HI            7
`define FALL_RATE_LO            6
`define FALL_STEP_HI            5
`define FALL_STEP_LO            4
`define RISE_RATE_HI            3
`define RISE_RATE_LO            2
`define RISE_STEP_HI            1
`define RISE_STEP_LO            0

// Rate and step encodings
`define RATE_EVERY_1            2'h0
`define RATE_EVERY_2            2'h1
`define RATE_EVERY_4            2'h2
`define RATE_INSTANT            2'h3
`define STEP_4DB                2'h0
`define STEP_2DB                2'h1
`define STEP_1DB                2'h2
`define STEP_HALF_DB            2'h3

// Volume codes in half-dB units, larger code means more attenuation
`define VOL_CODES_4DB           9'h008
`define VOL_CODES_2DB           9'h004
`define VOL_CODES_1DB           9'h002
`define VOL_CODES_HALF_DB       9'h001
`define VOL_MUTE_CODE           8'hFF

`endif

// ==== dsp_vol_ctrl_properties.sv ====
// Port-level checker for the mode and volume control bank.
// Sees only the bank's ports; bound to every instance below.
`timescale 1ns/1ps
module dsp_vol_ctrl_checker #(
  parameter PACE_W = 2
) (
  input wire       CLK,
  input wire       RESET,
  input wire       REG_WE,
  input wire       REG_RE,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire [7:0] REG_RDATA,
  input wire       REG_RVALID,
  input wire       FS_TICK,
  input wire       SOFT_MUTE,
  input wire       EMERGENCY,
  input wire       PARALLEL_BRIDGED_OUTPUT,
  input wire       FORCE_LEFT_HIGHZ,
  input wire       FORCE_RIGHT_HIGHZ,
  input wire [1:0] PROGRAM_SEL,
  input wire       BUILTIN_COEFF_SEL,
  input wire [7:0] VOLUME_LEVEL,
  input wire       VOLUME_MUTED,
  input wire       RAMP_ACTIVE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // Write to the mode register; output lags it by two edges
  wire wr_prog = REG_WE && (REG_ADDR == 8'h40);
  wire free    = !PARALLEL_BRIDGED_OUTPUT;

  a_left_force: assert property (
    (wr_prog && REG_WDATA[3]) ##1 free |=> FORCE_LEFT_HIGHZ)
    else $error("left force not applied");
  a_right_force: assert property (
    (wr_prog && REG_WDATA[2]) ##1 free |=> FORCE_RIGHT_HIGHZ)
    else $error("right force not applied");
  a_force_holds: assert property (
    FORCE_LEFT_HIGHZ && free && !$past(wr_prog) |=> FORCE_LEFT_HIGHZ)
    else $error("left force dropped without write");
  a_bridged_blocks: assert property (!free |=> !FORCE_LEFT_HIGHZ && !FORCE_RIGHT_HIGHZ)
    else $error("force active in bridged mode");
  // Mid-frame switching would mix configurations within a sample
  a_mode_at_frame: assert property (
    !$past(FS_TICK) |-> $stable(PROGRAM_SEL) && $stable(BUILTIN_COEFF_SEL))
    else $error("mode changed off frame boundary");
  a_mute_code: assert property (VOLUME_MUTED == (VOLUME_LEVEL == 8'hFF))
    else $error("mute flag disagrees with code");
  a_level_only_ramping: assert property ($changed(VOLUME_LEVEL) |-> $past(RAMP_ACTIVE))
    else $error("level moved while at target");
  a_ctrl_ro_bits: assert property (
    REG_RE && REG_ADDR == 8'h46 |=> REG_RDATA[2:1] == 2'b00)
    else $error("read-only bits not zero");

  c_both_forced: cover property (FORCE_LEFT_HIGHZ && FORCE_RIGHT_HIGHZ);
  c_muted: cover property (VOLUME_MUTED && EMERGENCY);
  c_prog_switch: cover property ($past(FS_TICK) && $changed(PROGRAM_SEL));
endmodule

bind dsp_mode_and_volume_ramp_ctrl dsp_vol_ctrl_checker #(.PACE_W(PACE_W)) u_chk (
  .CLK(CLK), .RESET(RESET), .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .FS_TICK(FS_TICK),
  .SOFT_MUTE(SOFT_MUTE), .EMERGENCY(EMERGENCY), .PARALLEL_BRIDGED_OUTPUT(PARALLEL_BRIDGED_OUTPUT),
  .FORCE_LEFT_HIGHZ(FORCE_LEFT_HIGHZ), .FORCE_RIGHT_HIGHZ(FORCE_RIGHT_HIGHZ),
  .PROGRAM_SEL(PROGRAM_SEL), .BUILTIN_COEFF_SEL(BUILTIN_COEFF_SEL), .VOLUME_LEVEL(VOLUME_LEVEL),
  .VOLUME_MUTED(VOLUME_MUTED), .RAMP_ACTIVE(RAMP_ACTIVE));

// ==== fs_update_pacer.v ====
// Sample-period pacer: turns sample ticks into volume update pulses.
// Assumes FS tick is a one-cycle pulse on the same clock, once per sample.
`timescale 1ns/1ps
`include "dsp_vol_consts.vh"

module fs_update_pacer #(
  parameter CNT_W = 2
) (
  input  wire             CLK,
  input  wire             RESET,
  input  wire             FS_TICK,
  input  wire             RESTART,
  input  wire [1:0]       RATE,
  output wire             UPDATE
);

  reg  [CNT_W-1:0] cnt_q;
  reg  [CNT_W-1:0] cnt_d;
  reg  [CNT_W-1:0] last_count;

  // Terminal count: one, two or four sample periods per update
  always @* begin
    case (RATE)
      `RATE_EVERY_1: last_count = {CNT_W{1'b0}};
      `RATE_EVERY_2: last_count = {{(CNT_W-1){1'b0}}, 1'b1};
      `RATE_EVERY_4: last_count = {CNT_W{1'b1}};
      default:       last_count = {CNT_W{1'b0}};
    endcase
  end

  assign UPDATE = FS_TICK && (cnt_q >= last_count) && !RESTART;

  // Count ticks; restart so a new ramp waits a full period
  always @* begin
    cnt_d = cnt_q;
    if (RESTART) begin
      cnt_d = {CNT_W{1'b0}};
    end else if (UPDATE) begin
      cnt_d = {CNT_W{1'b0}};
    end else if (FS_TICK) begin
      cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge CLK) begin
    if (RESET) begin
      cnt_q <= {CNT_W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// ==== testbench.sv ====
// Self-checking bench for the mode and volume control bank.
// Drives the register port and sample ticks directly; no far-side model.
`timescale 1ns/1ps
module testbench;
  logic        CLK = 0, RESET = 1, REG_WE = 0, REG_RE = 0, FS_TICK = 0;
  logic        SOFT_MUTE = 0, EMERGENCY = 0, PARALLEL_BRIDGED_OUTPUT = 0;
  logic [7:0]  REG_ADDR = 8'h00, REG_WDATA = 8'h00;
  wire  [7:0]  REG_RDATA, VOLUME_LEVEL;
  wire  [1:0]  PROGRAM_SEL;
  wire         REG_RVALID, FORCE_LEFT_HIGHZ, FORCE_RIGHT_HIGHZ, BUILTIN_COEFF_SEL;
  wire         VOLUME_MUTED, RAMP_ACTIVE;
  integer      n_errors = 0, num_checks = 0, i, k;
  logic [1:0]  pv;
  // Ramp cases: setup, target, step in codes, ticks per update, update count
  logic [39:0] ramps [0:11] = '{40'h3338010108, 40'h5045040204, 40'h8056080403,
    40'h205B020103, 40'h0440080204, 40'h0930040404, 40'h0229020104, 40'h0327010102,
    40'hC0FE000000, 40'h33FF010101, 40'h0C00000000, 40'hC0E0000000};

  dsp_mode_and_volume_ramp_ctrl dut (.CLK(CLK), .RESET(RESET), .REG_WE(REG_WE),
    .REG_RE(REG_RE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .FS_TICK(FS_TICK), .SOFT_MUTE(SOFT_MUTE), .EMERGENCY(EMERGENCY),
    .PARALLEL_BRIDGED_OUTPUT(PARALLEL_BRIDGED_OUTPUT), .FORCE_LEFT_HIGHZ(FORCE_LEFT_HIGHZ),
    .FORCE_RIGHT_HIGHZ(FORCE_RIGHT_HIGHZ), .PROGRAM_SEL(PROGRAM_SEL),
    .BUILTIN_COEFF_SEL(BUILTIN_COEFF_SEL), .VOLUME_LEVEL(VOLUME_LEVEL),
    .VOLUME_MUTED(VOLUME_MUTED), .RAMP_ACTIVE(RAMP_ACTIVE));

  // 125 MHz clock, reset for three cycles
  always #4 CLK = ~CLK;
  initial begin
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
  end

  task chk(input [8:0] seen, input [8:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task wr(input [7:0] a, input [7:0] d);
    @(posedge CLK);
    REG_WE <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WE <= 1'b0;
  endtask

  // Answer is valid for one cycle only, so it is looked at right after the edge
  task rd(input [7:0] a, input [7:0] e);
    @(posedge CLK);
    REG_RE <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RE <= 1'b0;
    #1 chk({REG_RVALID, REG_RDATA}, {1'b1, e});
  endtask

  task tick;
    @(posedge CLK);
    FS_TICK <= 1'b1;
    @(posedge CLK);
    FS_TICK <= 1'b0;
    #1;
  endtask

  task settle;
    repeat (2) @(posedge CLK);
    #1;
  endtask

  // First step timing is left open, so only later spacing is judged
  task watch(input [7:0] t, input [7:0] st, input [7:0] gap, input [7:0] ups);
    logic [7:0] prev, n, d;
    integer     last;
    logic       bad;
    repeat (3) @(posedge CLK);
    #1 prev = VOLUME_LEVEL;
    chk({8'h00, RAMP_ACTIVE}, {8'h00, ups != 8'h00});
    n = 0;
    last = 0;
    bad = 0;
    for (k = 1; k < 200 && VOLUME_LEVEL !== t; k++) begin
      tick;
      if (VOLUME_LEVEL !== prev) begin
        d = (VOLUME_LEVEL > prev) ? VOLUME_LEVEL - prev : prev - VOLUME_LEVEL;
        if (n > 0 && k - last != gap) bad = 1;
        if (d > st || (d < st && VOLUME_LEVEL !== t)) bad = 1;
        n = n + 1;
        last = k;
        prev = VOLUME_LEVEL;
      end
    end
    chk({VOLUME_MUTED, VOLUME_LEVEL}, {t == 8'hFF, t});
    chk({8'h00, RAMP_ACTIVE}, 9'h000);
    chk({1'b0, n}, {1'b0, ups});
    chk({8'h00, bad}, 9'h000);
  endtask

  initial begin
    #100000;
    n_errors = n_errors + 1;
    final_report;
  end

  initial begin
    repeat (5) @(posedge CLK);
    #1 chk({3'h0, VOLUME_MUTED, FORCE_LEFT_HIGHZ, FORCE_RIGHT_HIGHZ, PROGRAM_SEL,
      BUILTIN_COEFF_SEL}, 9'h003);
    chk({1'b0, VOLUME_LEVEL}, 9'h030);
    rd(8'h40, 8'h01);
    rd(8'h46, 8'h01);
    rd(8'h4C, 8'h30);
    rd(8'h4E, 8'h33);
    rd(8'h4F, 8'h30);
    rd(8'h41, 8'h00);
    wr(8'h46, 8'hFF);
    rd(8'h46, 8'hF9);
    wr(8'h41, 8'h5A);
    rd(8'h41, 8'h00);
    $display("register test done");
    // Program applies only on the following frame tick
    pv = 2'h1;
    for (i = 0; i < 4; i++) begin
      wr(8'h40, i[7:0]);
      settle;
      chk({7'h0, PROGRAM_SEL}, {7'h0, pv});
      tick;
      chk({7'h0, PROGRAM_SEL}, i[8:0]);
      pv = i[1:0];
    end
    wr(8'h46, 8'h00);
    settle;
    chk({8'h00, BUILTIN_COEFF_SEL}, 9'h001);
    tick;
    chk({8'h00, BUILTIN_COEFF_SEL}, 9'h000);
    $display("mode test done");
    wr(8'h40, 8'h0C);
    settle;
    chk({7'h0, FORCE_LEFT_HIGHZ, FORCE_RIGHT_HIGHZ}, 9'h003);
    @(posedge CLK);
    PARALLEL_BRIDGED_OUTPUT <= 1'b1;
    settle;
    chk({7'h0, FORCE_LEFT_HIGHZ, FORCE_RIGHT_HIGHZ}, 9'h000);
    @(posedge CLK);
    PARALLEL_BRIDGED_OUTPUT <= 1'b0;
    settle;
    chk({7'h0, FORCE_LEFT_HIGHZ, FORCE_RIGHT_HIGHZ}, 9'h003);
    wr(8'h40, 8'h04);
    settle;
    chk({7'h0, FORCE_LEFT_HIGHZ, FORCE_RIGHT_HIGHZ}, 9'h001);
    $display("force test done");
    for (i = 0; i < 12; i++) begin
      wr(8'h4E, ramps[i][39:32]);
      wr(8'h4C, ramps[i][31:24]);
      watch(ramps[i][31:24], ramps[i][23:16], ramps[i][15:8], ramps[i][7:0]);
    end
    $display("ramp test done");
    // Emergency uses its own setting while normal fall is instant
    wr(8'h4F, 8'h40);
    @(posedge CLK);
    EMERGENCY <= 1'b1;
    watch(8'hFF, 8'h08, 8'h02, 8'h04);
    @(posedge CLK);
    EMERGENCY <= 1'b0;
    watch(8'hE0, 8'h08, 8'h01, 8'h04);
    wr(8'h4E, 8'h33);
    @(posedge CLK);
    SOFT_MUTE <= 1'b1;
    watch(8'hFF, 8'h01, 8'h01, 8'h1F);
    $display("mute test done");
    final_report;
  end
endmodule
